// ==== asp_cfg.svh ====
// Constants for the stereo audio serial output port: AHB offsets, field
// positions, reset values and sample-rate limits.
// Assumes a single 40 MHz system clock; rate thresholds are in Hz.
//
// Contract
// - TDM frame starts at frame_sync rise, slot 0 data goes first
// - TDM slots follow slot 0 back to back in ascending order
// - TDM frame_sync and data bits launch on bit_clock rising edges
// - Bit clocks beyond the active words carry zero on serial data
// - TDM frame_sync may be one bit clock wide or a multiple
// - I2S left MSB on falling edge, second cycle after frame_sync falls
// - I2S right MSB on falling edge, second cycle after frame_sync rises
// - I2S bits after the MSB launch on bit_clock falling edges
// - I2S master changes frame_sync on bit_clock rising edges
// - I2S frame_sync low phase lasts at least left slots times 32
// - I2S frame_sync high phase lasts at least right slots times 32
// - Slave mode sets up its own clocking from measured rate and ratio
// - 48 kHz family ratios 16 to 512, with listed reserved cases
// - 44.1 kHz family uses the same ratios, with listed reserved cases
// - Master reference clock on second mode pin, 256 or 512 fs
// - Master mode supports only 44.1 kHz and 48 kHz sample rates
// - Select low means slave with clock inputs, high means master driving
// - Format select low means I2S, high means TDM
// - Every sample is a 32-bit word sent MSB first
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

`define ASP_CLK_HZ 40000000
`define ASP_WORD_BITS 32

// Register offsets (byte addresses)
`define ASP_OFF_CTRL 32'h00000000
`define ASP_OFF_LEFT 32'h00000004
`define ASP_OFF_RIGHT 32'h00000008
`define ASP_OFF_STATUS 32'h0000000c
`define ASP_OFF_PERIOD 32'h00000010

// Field positions and reset values
`define ASP_CTRL_EN 0
`define ASP_ST_VALID 0
`define ASP_ST_MASTER 1
`define ASP_ST_TDM 2
`define ASP_ST_RATIO_LSB 8
`define ASP_CTRL_RST 1'b1

// Frame rate limits in Hz, split points between neighbouring rates
`define ASP_FS_MIN_HZ 7000
`define ASP_FS_MAX_HZ 200000
`define ASP_FS_7K_8K_HZ 7675
`define ASP_FS_8K_14K_HZ 11350
`define ASP_FS_14K_16K_HZ 15350
`define ASP_FS_HIGH2_HZ 140000
`define ASP_FS_HIGH1_HZ 70000
`define ASP_FS_MST_LO_HZ 42000
`define ASP_FS_MST_HI_HZ 50000

`endif

// ==== asp_pkg.sv ====
// Types shared by the audio serial port.
// Assumes nothing beyond the configuration header.
package asp_pkg;
    // Phase of the I2S MSB delay after a frame_sync change
    typedef enum logic [1:0] {
        ASP_ARM_IDLE = 2'b00,
        ASP_ARM_WAIT = 2'b01,
        ASP_ARM_READY = 2'b10
    } asp_arm_t;
endpackage

// ==== asp_sync.sv ====
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/10ps
module asp_sync #(
    parameter int W = 6
) (
    // System
    input wire logic clk,
    input wire logic rstn,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            // First stage feeds only the second stage
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta_ff <= 1'b0;
                    sync_ff <= 1'b0;
                end else begin
                    meta_ff <= d[i];
                    sync_ff <= meta_ff;
                end
            end
            assign q[i] = sync_ff;
        end
    endgenerate
endmodule

// ==== asp_serial_port.sv ====
// Stereo audio serial output port with an AHB-Lite register slave.
// Assumes bus and pins share clk; link pins are sampled through asp_sync,
// so link clocks must stay well below half of clk.
//
// Design decisions made here: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "asp_cfg.svh"
module asp_serial_port #(
    parameter logic [12:0] FRAME_MAX_CLKS = 13'(`ASP_CLK_HZ / `ASP_FS_MIN_HZ),
    parameter logic [12:0] SLOW_SPLIT_CLKS = 13'(`ASP_CLK_HZ / `ASP_FS_7K_8K_HZ)
) (
    // System
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Strap and reference pins
    input wire logic masterSlaveSelect,
    input wire logic formatSelect,
    input wire logic firstModePin,
    input wire logic secondModePin,
    // Audio link
    input wire logic bitClockIn,
    output logic bitClockOut,
    output logic bitClockOen,
    input wire logic frameSyncIn,
    output logic frameSyncOut,
    output logic frameSyncOen,
    output logic serialDataOut
);
    localparam logic [12:0] P_FAST = 13'(`ASP_CLK_HZ / `ASP_FS_MAX_HZ);
    localparam logic [12:0] P_HIGH2 = 13'(`ASP_CLK_HZ / `ASP_FS_HIGH2_HZ);
    localparam logic [12:0] P_HIGH1 = 13'(`ASP_CLK_HZ / `ASP_FS_HIGH1_HZ);
    localparam logic [12:0] P_8K14K = 13'(`ASP_CLK_HZ / `ASP_FS_8K_14K_HZ);
    localparam logic [12:0] P_14K16K = 13'(`ASP_CLK_HZ / `ASP_FS_14K_16K_HZ);
    localparam logic [12:0] P_MST_LO = 13'(`ASP_CLK_HZ / `ASP_FS_MST_HI_HZ);
    localparam logic [12:0] P_MST_HI = 13'(`ASP_CLK_HZ / `ASP_FS_MST_LO_HZ);

    logic [5:0] pinS;
    logic bclkS, fsS, refS, md0S, tdm, master;
    logic bclkPrev_ff, refPrev_ff, bclkOut_ff, fsOut_ff, bclkOen_ff, fsOen_ff;
    logic nxt_bclkPrev, nxt_refPrev, nxt_bclkOut, nxt_fsOut, nxt_bclkOen, nxt_fsOen;
    logic [1:0] divCnt_ff, nxt_divCnt;
    logic [5:0] mBit_ff, nxt_mBit;
    logic fsPrev_ff, nxt_fsPrev, valid_ff, nxt_valid, runEn_ff, nxt_runEn;
    logic [9:0] bitCnt_ff, nxt_bitCnt, ratio_ff, nxt_ratio, newRatio;
    logic [12:0] perCnt_ff, nxt_perCnt, period_ff, nxt_period, newPer;
    asp_pkg::asp_arm_t arm_ff, nxt_arm;
    logic selR_ff, nxt_selR, dout_ff, nxt_dout, ctrlEn_ff, nxt_ctrlEn;
    logic [63:0] shReg_ff, nxt_shReg;
    logic [6:0] bitsLeft_ff, nxt_bitsLeft;
    logic [31:0] leftS_ff, nxt_leftS, rightS_ff, nxt_rightS;
    logic [31:0] wrAddr_ff, nxt_wrAddr, rdata_ff, nxt_rdata;
    logic wrPend_ff, nxt_wrPend;
    logic refRise, divWrap, bRise, bFall, mFs, fsNow;
    logic tdmStart, i2sEdge, frameStart, reserved, rateOk, okRun, nxt_okRun;
    logic tdmLoad, i2sLoad;
    logic [1:0] divTop;

    // Every pin from the link side is synchronised before use
    asp_sync #(.W(6)) uSync (
        .clk(clk),
        .rstn(rstn),
        .d({bitClockIn, frameSyncIn, secondModePin, firstModePin, formatSelect,
            masterSlaveSelect}),
        .q(pinS)
    );
    assign {bclkS, fsS, refS, md0S, tdm, master} = pinS;

    // Ratio set shared by both rate families
    function automatic logic ratioLegal(input logic [9:0] r);
        case (r)
            10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h060, 10'h080,
            10'h0c0, 10'h100, 10'h180, 10'h200: ratioLegal = 1'b1;
            default: ratioLegal = 1'b0;
        endcase
    endfunction

    // Bit clock events; master divides the reference, slave edge-detects
    always_comb begin
        refRise = refS && !refPrev_ff;
        divTop = md0S ? 2'h3 : 2'h1;
        divWrap = refRise && (divCnt_ff == divTop);
        bRise = master ? (divWrap && !bclkOut_ff) : (bclkS && !bclkPrev_ff);
        bFall = master ? (divWrap && bclkOut_ff) : (!bclkS && bclkPrev_ff);
        mFs = tdm ? (mBit_ff == 6'h00) : mBit_ff[5];
        fsNow = master ? mFs : fsS;
        tdmStart = bRise && tdm && fsNow && !fsPrev_ff;
        i2sEdge = bRise && !tdm && (fsNow != fsPrev_ff);
        frameStart = tdmStart || (i2sEdge && !fsNow);
        tdmLoad = tdmStart;
        i2sLoad = !tdm && bFall && (arm_ff == asp_pkg::ASP_ARM_READY);
    end

    // Measured frame figures and their legality
    always_comb begin
        newRatio = (bitCnt_ff == 10'h3ff) ? bitCnt_ff : bitCnt_ff + 10'h001;
        newPer = (perCnt_ff == 13'h1fff) ? perCnt_ff : perCnt_ff + 13'h0001;
        reserved = (newPer < P_HIGH2 && newRatio >= 10'h0c0)
            || (newPer < P_HIGH1 && newRatio >= 10'h180)
            || (newPer > SLOW_SPLIT_CLKS && newRatio <= 10'h020)
            || (newPer > P_8K14K && newRatio <= 10'h018)
            || (newPer > P_14K16K && newPer <= P_8K14K && newRatio == 10'h010);
        if (master) begin
            rateOk = newPer >= P_MST_LO && newPer <= P_MST_HI;
        end else begin
            rateOk = ratioLegal(newRatio) && !reserved
                && newPer >= P_FAST && newPer <= FRAME_MAX_CLKS;
        end
        okRun = runEn_ff && valid_ff;
        nxt_okRun = frameStart ? (ctrlEn_ff && rateOk) : okRun;
    end

    // Next state of the link side and the measured ratio, period and valid status
    always_comb begin
        nxt_bclkPrev = bclkS;
        nxt_refPrev = refS;
        nxt_divCnt = divCnt_ff;
        nxt_bclkOut = bclkOut_ff;
        nxt_fsOut = fsOut_ff;
        nxt_bclkOen = !master;
        nxt_fsOen = !master;
        nxt_mBit = mBit_ff;
        nxt_fsPrev = fsPrev_ff;
        nxt_bitCnt = bitCnt_ff;
        nxt_perCnt = newPer;
        nxt_ratio = ratio_ff;
        nxt_period = period_ff;
        nxt_valid = valid_ff;
        nxt_runEn = runEn_ff;
        nxt_arm = arm_ff;
        nxt_selR = selR_ff;
        nxt_shReg = shReg_ff;
        nxt_bitsLeft = bitsLeft_ff;
        nxt_dout = dout_ff;
        if (refRise) begin
            nxt_divCnt = divWrap ? 2'h0 : divCnt_ff + 2'h1;
        end
        if (divWrap && master) begin
            nxt_bclkOut = !bclkOut_ff;
        end
        if (!master) begin
            nxt_bclkOut = 1'b0;
            nxt_fsOut = 1'b0;
        end
        if (bRise) begin
            nxt_fsPrev = fsNow;
            nxt_bitCnt = (bitCnt_ff == 10'h3ff) ? bitCnt_ff : bitCnt_ff + 10'h001;
            if (master) begin
                nxt_fsOut = mFs;
                nxt_mBit = mBit_ff + 6'h01;
            end
        end
        if (frameStart) begin
            nxt_bitCnt = 10'h000;
            nxt_perCnt = 13'h0000;
            nxt_ratio = newRatio;
            nxt_period = newPer;
            nxt_valid = rateOk;
            nxt_runEn = ctrlEn_ff;
        end
        if (tdm) begin
            nxt_arm = asp_pkg::ASP_ARM_IDLE;
            if (tdmLoad) begin
                nxt_shReg = {leftS_ff[30:0], rightS_ff, 1'b0};
                nxt_dout = leftS_ff[31];
                nxt_bitsLeft = 7'h3f;
            end else if (bRise) begin
                nxt_dout = (bitsLeft_ff != 7'h00) && shReg_ff[63];
                nxt_shReg = {shReg_ff[62:0], 1'b0};
                if (bitsLeft_ff != 7'h00) begin
                    nxt_bitsLeft = bitsLeft_ff - 7'h01;
                end
            end
        end else begin
            if (i2sEdge) begin
                nxt_arm = asp_pkg::ASP_ARM_WAIT;
                nxt_selR = fsNow;
            end else if (bRise && arm_ff == asp_pkg::ASP_ARM_WAIT) begin
                nxt_arm = asp_pkg::ASP_ARM_READY;
            end
            if (i2sLoad) begin
                nxt_arm = asp_pkg::ASP_ARM_IDLE;
                nxt_shReg = {(selR_ff ? rightS_ff[30:0] : leftS_ff[30:0]), 33'h0};
                nxt_dout = selR_ff ? rightS_ff[31] : leftS_ff[31];
                nxt_bitsLeft = 7'h1f;
            end else if (bFall) begin
                nxt_dout = (bitsLeft_ff != 7'h00) && shReg_ff[63];
                nxt_shReg = {shReg_ff[62:0], 1'b0};
                if (bitsLeft_ff != 7'h00) begin
                    nxt_bitsLeft = bitsLeft_ff - 7'h01;
                end
            end
        end
        nxt_dout = nxt_dout && nxt_okRun;
    end

    // AHB-Lite slave: zero wait, writes land in the data phase
    always_comb begin
        nxt_ctrlEn = ctrlEn_ff;
        nxt_leftS = leftS_ff;
        nxt_rightS = rightS_ff;
        nxt_wrPend = hsel && htrans[1] && hready && hwrite;
        nxt_wrAddr = haddr;
        nxt_rdata = rdata_ff;
        if (wrPend_ff) begin
            if (wrAddr_ff == `ASP_OFF_CTRL) begin
                nxt_ctrlEn = hwdata[`ASP_CTRL_EN];
            end else if (wrAddr_ff == `ASP_OFF_LEFT) begin
                nxt_leftS = hwdata;
            end else if (wrAddr_ff == `ASP_OFF_RIGHT) begin
                nxt_rightS = hwdata;
            end
        end
        // Reads see a write still in its data phase, so no stale readback
        if (hsel && htrans[1] && hready && !hwrite) begin
            nxt_rdata = 32'h0;
            if (haddr == `ASP_OFF_CTRL) begin
                nxt_rdata[`ASP_CTRL_EN] = nxt_ctrlEn;
            end else if (haddr == `ASP_OFF_LEFT) begin
                nxt_rdata = nxt_leftS;
            end else if (haddr == `ASP_OFF_RIGHT) begin
                nxt_rdata = nxt_rightS;
            end else if (haddr == `ASP_OFF_STATUS) begin
                nxt_rdata[`ASP_ST_VALID] = okRun;
                nxt_rdata[`ASP_ST_MASTER] = master;
                nxt_rdata[`ASP_ST_TDM] = tdm;
                nxt_rdata[`ASP_ST_RATIO_LSB +: 10] = ratio_ff;
            end else if (haddr == `ASP_OFF_PERIOD) begin
                nxt_rdata[12:0] = period_ff;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bclkPrev_ff <= 1'b0;
            refPrev_ff <= 1'b0;
            divCnt_ff <= 2'h0;
            bclkOut_ff <= 1'b0;
            fsOut_ff <= 1'b0;
            bclkOen_ff <= 1'b1;
            fsOen_ff <= 1'b1;
            mBit_ff <= 6'h00;
            fsPrev_ff <= 1'b0;
            bitCnt_ff <= 10'h000;
            perCnt_ff <= 13'h0000;
            ratio_ff <= 10'h000;
            period_ff <= 13'h0000;
            valid_ff <= 1'b0;
            runEn_ff <= 1'b0;
            arm_ff <= asp_pkg::ASP_ARM_IDLE;
            selR_ff <= 1'b0;
            shReg_ff <= 64'h0;
            bitsLeft_ff <= 7'h00;
            dout_ff <= 1'b0;
            ctrlEn_ff <= `ASP_CTRL_RST;
            leftS_ff <= 32'h0;
            rightS_ff <= 32'h0;
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 32'h0;
            rdata_ff <= 32'h0;
        end else begin
            bclkPrev_ff <= nxt_bclkPrev;
            refPrev_ff <= nxt_refPrev;
            divCnt_ff <= nxt_divCnt;
            bclkOut_ff <= nxt_bclkOut;
            fsOut_ff <= nxt_fsOut;
            bclkOen_ff <= nxt_bclkOen;
            fsOen_ff <= nxt_fsOen;
            mBit_ff <= nxt_mBit;
            fsPrev_ff <= nxt_fsPrev;
            bitCnt_ff <= nxt_bitCnt;
            perCnt_ff <= nxt_perCnt;
            ratio_ff <= nxt_ratio;
            period_ff <= nxt_period;
            valid_ff <= nxt_valid;
            runEn_ff <= nxt_runEn;
            arm_ff <= nxt_arm;
            selR_ff <= nxt_selR;
            shReg_ff <= nxt_shReg;
            bitsLeft_ff <= nxt_bitsLeft;
            dout_ff <= nxt_dout;
            ctrlEn_ff <= nxt_ctrlEn;
            leftS_ff <= nxt_leftS;
            rightS_ff <= nxt_rightS;
            wrPend_ff <= nxt_wrPend;
            wrAddr_ff <= nxt_wrAddr;
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs straight from flip-flops, except hreadyout and hresp, which are tied constants
    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1 | hsize[0] & 1'b0;
    assign hresp = 1'b0;
    assign bitClockOut = bclkOut_ff;
    assign bitClockOen = bclkOen_ff;
    assign frameSyncOut = fsOut_ff;
    assign frameSyncOen = fsOen_ff;
    assign serialDataOut = dout_ff;

    // Checks on the serial framing
    a_tdm_msb_launch: assert property (@(posedge clk) disable iff (!rstn)
        (tdmLoad && nxt_okRun) |=> serialDataOut == $past(leftS_ff[31]))
        else $error("TDM slot 0 MSB not launched at frame start");
    a_tdm_slot_order: assert property (@(posedge clk) disable iff (!rstn)
        (tdm && bRise && !tdmStart && bitsLeft_ff != 7'h00)
        |=> bitsLeft_ff == $past(bitsLeft_ff) - 7'h01)
        else $error("TDM bits not sent back to back");
    a_tdm_rise_only: assert property (@(posedge clk) disable iff (!rstn)
        (tdm && $past(tdm) && !$past(bRise) && $past(nxt_okRun) == $past(okRun))
        |-> $stable(serialDataOut))
        else $error("TDM data changed away from a rising edge");
    a_pad_zero: assert property (@(posedge clk) disable iff (!rstn)
        (bitsLeft_ff == 7'h00 && ((tdm && bRise && !tdmStart) || (!tdm && bFall && !i2sLoad)))
        |=> !serialDataOut)
        else $error("Nonzero data beyond the active words");
    a_i2s_left_msb: assert property (@(posedge clk) disable iff (!rstn)
        (i2sLoad && !selR_ff && nxt_okRun) |=> serialDataOut == $past(leftS_ff[31]))
        else $error("I2S left MSB wrong");
    a_i2s_right_msb: assert property (@(posedge clk) disable iff (!rstn)
        (i2sLoad && selR_ff && nxt_okRun) |=> serialDataOut == $past(rightS_ff[31]))
        else $error("I2S right MSB wrong");
    a_i2s_fall_only: assert property (@(posedge clk) disable iff (!rstn)
        (!tdm && $past(!tdm) && !$past(bFall) && $past(nxt_okRun) == $past(okRun))
        |-> $stable(serialDataOut))
        else $error("I2S data changed away from a falling edge");
    a_master_fs_rise: assert property (@(posedge clk) disable iff (!rstn)
        (master && $past(master) && !$past(bRise)) |-> $stable(frameSyncOut))
        else $error("Master frame_sync changed away from a rising edge");
    a_mute_invalid: assert property (@(posedge clk) disable iff (!rstn)
        !okRun |-> !serialDataOut)
        else $error("Data sent while rate or ratio unsupported");
    a_pin_direction: assert property (@(posedge clk) disable iff (!rstn)
        master |=> (!bitClockOen && !frameSyncOen))
        else $error("Master does not drive clock pins");
    a_master_half: assert property (@(posedge clk) disable iff (!rstn)
        (master && $past(master) && !tdm && bRise && mBit_ff == 6'h20) |=> frameSyncOut)
        else $error("Master I2S frame_sync not high for right half");
endmodule

// ==== asp_host_model.sv ====
// Host end of the audio link: bit clock, frame sync and reference clock,
// and a capture of serial data words into a queue.
// Assumes the bench resolves the link wires and picks rate and ratio.
`timescale 1ns/10ps
module asp_host_model (
    // Frame shape chosen by the bench
    input wire logic tdm,
    input wire logic master,
    input wire logic fs512,
    input wire logic [17:0] rateHz,
    input wire logic [9:0] ratio,
    // Resolved link wires
    input wire logic bckWire,
    input wire logic fsWire,
    input wire logic sdo,
    // Host drive
    output logic bckDrv,
    output logic fsDrv,
    output logic refClk
);
    logic [32:0] got[$];
    logic [31:0] word;
    logic fsPrev;
    logic side;
    int b = 0;
    int pos = -100;
    int frameLen;
    int onesSeen;
    int extraOnes;
    int k = 0;
    int chgA = -100;
    int chgB = -100;
    logic sideB;

    initial begin
        bckDrv = 1'b0;
        fsDrv = 1'b0;
        refClk = 1'b0;
    end

    // One bit cycle per pass in slave mode, one reference clock half period in master mode, so a mode change is seen within a bit
    always begin : gen
        real half;
        half = 1.0e9 / (2.0 * real'(rateHz) * real'(ratio));
        if (master) begin
            #(1.0e9 / ((fs512 ? 1024.0 : 512.0) * real'(rateHz)));
            refClk = ~refClk;
        end else begin
            bckDrv = 1'b0;
            #1;
            fsDrv = tdm ? (b == 0) : (b >= int'(ratio) / 2);
            #(half - 1.0);
            bckDrv = 1'b1;
            #(half);
            b = (b + 1 >= int'(ratio)) ? 0 : b + 1;
        end
    end

    // Shift one bit into the word, or count stray ones past the words
    task automatic take();
        if (sdo === 1'b1) onesSeen++;
        if (pos >= 0 && pos < (tdm ? 64 : 32)) begin
            word = {word[30:0], sdo};
            if (pos % 32 == 31) got.push_back({tdm ? pos >= 32 : side, word});
        end else if (pos >= 0 && sdo !== 1'b0) begin
            extraOnes++;
        end
    endtask

    // TDM bits launch on rises, so they are taken on falls
    always @(negedge bckWire) if (tdm) begin
        if (fsWire === 1'b1 && fsPrev !== 1'b1) begin
            frameLen = pos + 1;
            pos = 0;
        end else begin
            pos++;
        end
        fsPrev = fsWire;
        take();
    end

    // I2S bits launch on falls; a word fills rises 2 to 33 after its sync
    // change, so at 32 bits a half its LSB lands after the next change.
    // Sampled 1 ns late since a master moves sync with its own clock edge.
    always @(posedge bckWire) if (!tdm) begin
        #1;
        k++;
        if (fsWire !== fsPrev) begin
            chgB = chgA;
            sideB = side;
            chgA = k;
            side = fsWire;
        end
        fsPrev = fsWire;
        word = {word[30:0], sdo};
        if (sdo === 1'b1) onesSeen++;
        if (k == chgA + 33 || k == chgB + 33) begin
            got.push_back({(k == chgA + 33) ? side : sideB, word});
        end else if ((k < chgA + 2 || k > chgA + 33) && (k < chgB + 2 || k > chgB + 33)
                     && sdo !== 1'b0) begin
            extraOnes++;
        end
    end
endmodule

// ==== tb_top.sv ====
// Bench for the audio serial port: AHB register access and link traffic
// in slave and master modes, words checked against the written samples.
// Assumes asp_host_model on the far side of the link.
`timescale 1ns/10ps
module tb_top;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hreadyout, hresp, msSel = 1'b0, fmtSel = 1'b1, modeSel = 1'b0;
    logic [17:0] rateHz = 18'd32000;
    logic [9:0] ratio = 10'd96;
    logic refClk, hostBck, hostFs, bckOut, bckOen, fsOut, fsOen, sdo;
    int nErrors = 0;
    int checksDone = 0;
    // Active-low enables pick who drives each link wire
    wire logic bckWire = bckOen ? hostBck : bckOut;
    wire logic fsWire = fsOen ? hostFs : fsOut;

    assign hready = hreadyout;
    always #12.5 clk = ~clk;

    asp_serial_port uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .masterSlaveSelect(msSel), .formatSelect(fmtSel), .firstModePin(modeSel),
        .secondModePin(refClk), .bitClockIn(bckWire), .bitClockOut(bckOut),
        .bitClockOen(bckOen), .frameSyncIn(fsWire), .frameSyncOut(fsOut),
        .frameSyncOen(fsOen), .serialDataOut(sdo));

    asp_host_model host (.tdm(fmtSel), .master(msSel), .fs512(modeSel), .rateHz(rateHz),
        .ratio(ratio), .bckWire(bckWire), .fsWire(fsWire), .sdo(sdo), .bckDrv(hostBck),
        .fsDrv(hostFs), .refClk(refClk));

    task automatic endOfTest();
        if (nErrors == 0 && checksDone > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            nErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Single word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // Fresh samples, switch mode, settle three frames, capture three
    task automatic runMode(input logic t, input logic m, input int rate, input int r,
                           input logic ok);
        logic [31:0] rd, lv, rv;
        logic [32:0] w;
        int per;
        lv = $urandom | 32'h80000000;
        rv = $urandom;
        ahb(1'b1, 32'h4, lv, rd);
        ahb(1'b1, 32'h8, rv, rd);
        ahb(1'b0, 32'h4, 32'h0, rd);
        check("left", rd, lv);
        fmtSel <= t;
        msSel <= m;
        rateHz <= 18'(rate);
        ratio <= 10'(r);
        repeat (120000000 / rate) @(posedge clk);
        host.got.delete();
        host.onesSeen = 0;
        host.extraOnes = 0;
        repeat (120000000 / rate) @(posedge clk);
        check("extra", host.extraOnes, 0);
        check("short", 32'(ok && host.got.size() < 4), 0);
        if (!ok) check("mute", host.onesSeen, 0);
        if (t && m) check("frame", host.frameLen, 64);
        check("oen", {30'h0, bckOen, fsOen}, {30'h0, ~m, ~m});
        while (host.got.size() > 0) begin
            w = host.got.pop_front();
            check("word", w[31:0], ok ? (w[32] ? rv : lv) : 32'h0);
        end
        ahb(1'b1, 32'hc, 32'hffffffff, rd);
        ahb(1'b0, 32'hc, 32'h0, rd);
        check("status", rd, {14'h0, 10'(r), 5'h0, t, m, ok});
        // Frame length in system clocks, a few clocks of sampling jitter allowed
        ahb(1'b0, 32'h10, 32'h0, rd);
        per = 40000000 / rate;
        check("period", 32'(rd + 4 > per && rd < per + 4), 32'h1);
    endtask

    initial begin
        logic [31:0] rd;
        void'($urandom(32'h81b8fc9f));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check("ctrl", rd, 32'h1);
        ahb(1'b1, 32'h14, 32'hffffffff, rd);
        ahb(1'b0, 32'h14, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        // Slave TDM, then the same muted by enable
        runMode(1'b1, 1'b0, 32000, 96, 1'b1);
        ahb(1'b1, 32'h0, 32'h0, rd);
        runMode(1'b1, 1'b0, 32000, 96, 1'b0);
        ahb(1'b1, 32'h0, 32'h1, rd);
        // Slave I2S, two reserved cases, then master TDM
        runMode(1'b0, 1'b0, 32000, 128, 1'b1);
        runMode(1'b0, 1'b0, 14700, 16, 1'b0);
        runMode(1'b0, 1'b0, 8000, 16, 1'b0);
        runMode(1'b1, 1'b1, 48000, 64, 1'b1);
        // Master I2S, then a 512 fs reference at a rate master mode refuses
        runMode(1'b0, 1'b1, 48000, 64, 1'b1);
        modeSel <= 1'b1;
        runMode(1'b1, 1'b1, 24000, 64, 1'b0);
        endOfTest();
    end

    // Watchdog about an eighth past the expected run length of some 2.22 ms
    initial begin
        #2500000;
        nErrors++;
        endOfTest();
    end
endmodule
